// ### src/csw_clock_switch.sv
// Purpose: Clock switch request and status registers with switch sequencer
// Assumes: APB slave on pclk; fuses and oscillator ready are async levels
// Notes: Zero-wait APB; request applies after the oscillator settles
//
// Behaviour
// [RULE_01] Request holds source field in bits 6:4
// [RULE_02] Request fields load from reset fuse code
// [RULE_03] Request holds divider field in bits 3:0
// [RULE_04] Reserved source write discards whole write
// [RULE_05] Switch disable fuse makes request read-only
// [RULE_06] Divider resets 0010 for 110, else 0000
// [RULE_07] Bit 7 reads zero, ignores writes
// [RULE_08] Status bits 6:4 show current source
// [RULE_09] Status bits 3:0 show current divider
// [RULE_10] Status resets equal to request fields
// [RULE_11] Status valid when user code starts
// [RULE_12] Writing source switches the system clock
// [RULE_13] Code 110 is 1 MHz, 000 32 MHz; hf_freq_32m is set from the reset fuse code only, not by later switches
// [RULE_14] Divider spans 1:1 up to 1:512
// [RULE_15] Status follows request after switch completes
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "csw_map.svh"

module csw_clock_switch (
  input wire logic pclk, // System clock, 10 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic [`CSW_ADDR_W-1:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write direction
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [2:0] reset_source_config, // Reset source fuse code
  input wire logic switch_enable_config, // Switch enable fuse
  input wire logic osc_ready, // Selected oscillator stable
  output logic [2:0] clk_src_sel, // Source driven to clock mux
  output logic [3:0] clk_div_sel, // Divider driven to postscaler
  output logic hf_freq_32m, // Reset fuse code selected the 32 MHz high-freq oscillator
  output logic switch_busy, // Switch in progress
  output logic code_run_enable, // Settled, user code may run
  output logic div_tick // Postscaler pulse for divider driven on clk_div_sel
);

  localparam logic [7:0] SettleCyc = 8'(`CSW_SETTLE_CYC);
  localparam logic [7:0] SyncCyc = 8'(`CSW_SYNC_STAGES);
  localparam logic [7:0] RsvdMask = `CSW_RSVD_MASK;

  csw_pkg::csw_top_s s_reg;
  csw_pkg::csw_top_s s_next;

  logic [`CSW_SYNC_W-1:0] sync_in;
  logic [`CSW_SYNC_W-1:0] sync_q;
  logic [2:0] cfg_src_s;
  logic cfg_swen_s;
  logic osc_ready_s;
  logic setup_ph;
  logic acc_wr;
  logic [2:0] wr_src;
  logic [3:0] wr_div;
  logic wr_rsvd;
  logic settle_done;
  logic [7:0] req_byte;
  logic [7:0] stat_byte;

  // Fuse and oscillator-ready pins pass two flip-flops before any logic sees them
  assign sync_in = {osc_ready, switch_enable_config, reset_source_config};

  csw_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sync_in),
    .sync_out(sync_q)
  );

  // Split the synchronised levels
  assign cfg_src_s = sync_q[2:0];
  assign cfg_swen_s = sync_q[3];
  assign osc_ready_s = sync_q[4];

  // Postscaler follows the divider actually in use
  csw_postscaler u_postscaler (
    .pclk(pclk),
    .presetn(presetn),
    .div_sel(s_reg.tgt_div),
    .tick(div_tick)
  );

  // Register images as software reads them
  always_comb begin
    req_byte = 8'h00; // RULE_07
    req_byte[`CSW_SRC_MSB:`CSW_SRC_LSB] = s_reg.req_src; // RULE_01
    req_byte[`CSW_DIV_MSB:`CSW_DIV_LSB] = s_reg.req_div; // RULE_03
    stat_byte = 8'h00; // RULE_07
    stat_byte[`CSW_SRC_MSB:`CSW_SRC_LSB] = s_reg.cur_src; // RULE_08
    stat_byte[`CSW_DIV_MSB:`CSW_DIV_LSB] = s_reg.cur_div; // RULE_09
  end

  // Bus phase decode and write field extraction
  always_comb begin
    setup_ph = psel && !penable;
    acc_wr = psel && penable && s_reg.pready && pwrite &&
             !s_reg.pslverr && (paddr == `CSW_REQ_OFS) && pstrb[0];
    wr_src = pwdata[`CSW_SRC_MSB:`CSW_SRC_LSB];
    wr_div = pwdata[`CSW_DIV_MSB:`CSW_DIV_LSB];
    wr_rsvd = RsvdMask[wr_src]; // RULE_04
    settle_done = (s_reg.cnt >= SettleCyc - 8'h01) && osc_ready_s;
  end

  // Next-state logic: bus slave, request register and sequencer
  always_comb begin
    s_next = s_reg;

    // Answer in the access phase straight after each setup cycle
    s_next.pready = setup_ph;
    s_next.pslverr = 1'b0;
    if (setup_ph) begin
      if (paddr == `CSW_REQ_OFS) begin
        s_next.prdata = {24'h000000, req_byte};
      end else if (paddr == `CSW_STAT_OFS) begin
        s_next.prdata = {24'h000000, stat_byte};
      end else begin
        s_next.prdata = 32'h00000000;
        s_next.pslverr = 1'b1;
      end
    end

    // Status register ignores writes; request takes only legal ones
    if (acc_wr && s_reg.swen && !wr_rsvd && // RULE_05 RULE_04
        (s_reg.st != csw_pkg::CSW_ST_LOAD)) begin
      s_next.req_src = wr_src; // RULE_01 RULE_12
      s_next.req_div = wr_div; // RULE_03
    end

    case (s_reg.st)
      // Wait until fuse levels have crossed both sync stages
      csw_pkg::CSW_ST_LOAD: begin
        if (s_reg.cnt >= SyncCyc) begin
          s_next.req_src = cfg_src_s; // RULE_02
          if (cfg_src_s == `CSW_SRC_HF_1M) begin
            s_next.req_div = `CSW_DIV_RST_HF_1M; // RULE_06
          end else begin
            s_next.req_div = `CSW_DIV_RST_OTHER; // RULE_06
          end
          if (cfg_src_s == `CSW_SRC_HF_1M) begin
            s_next.tgt_div = `CSW_DIV_RST_HF_1M; // RULE_10
          end else begin
            s_next.tgt_div = `CSW_DIV_RST_OTHER; // RULE_10
          end
          s_next.tgt_src = cfg_src_s; // RULE_10
          s_next.swen = cfg_swen_s; // RULE_05
          s_next.hf32 = (cfg_src_s == `CSW_SRC_HF_32M); // RULE_13
          s_next.busy = 1'b1;
          s_next.cnt = 8'h00;
          s_next.st = csw_pkg::CSW_ST_SETTLE;
        end else begin
          s_next.cnt = s_reg.cnt + 8'h01;
        end
      end

      // Initial oscillator settles before user code starts
      csw_pkg::CSW_ST_SETTLE: begin
        if (settle_done) begin
          s_next.cur_src = s_reg.tgt_src; // RULE_11 RULE_10
          s_next.cur_div = s_reg.tgt_div; // RULE_11 RULE_10
          s_next.run = 1'b1; // RULE_11
          s_next.busy = 1'b0;
          s_next.st = csw_pkg::CSW_ST_IDLE;
        end else if (s_reg.cnt < SettleCyc) begin
          s_next.cnt = s_reg.cnt + 8'h01;
        end
      end

      // Start a switch whenever the request differs from status
      csw_pkg::CSW_ST_IDLE: begin
        if ((s_reg.req_src != s_reg.cur_src) ||
            (s_reg.req_div != s_reg.cur_div)) begin
          s_next.tgt_src = s_reg.req_src; // RULE_12
          s_next.tgt_div = s_reg.req_div; // RULE_12
          s_next.busy = 1'b1;
          s_next.cnt = 8'h00;
          s_next.st = csw_pkg::CSW_ST_SWITCH;
        end
      end

      // New source settles, then status takes the accepted request
      csw_pkg::CSW_ST_SWITCH: begin
        if (settle_done) begin
          s_next.cur_src = s_reg.tgt_src; // RULE_15
          s_next.cur_div = s_reg.tgt_div; // RULE_15
          s_next.busy = 1'b0;
          s_next.st = csw_pkg::CSW_ST_IDLE;
        end else if (s_reg.cnt < SettleCyc) begin
          s_next.cnt = s_reg.cnt + 8'h01;
        end
      end

      default: begin
        s_next.st = csw_pkg::CSW_ST_LOAD;
      end
    endcase
  end

  // State register; reset takes constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign clk_src_sel = s_reg.tgt_src; // RULE_12
  assign clk_div_sel = s_reg.tgt_div;
  assign hf_freq_32m = s_reg.hf32; // RULE_13
  assign switch_busy = s_reg.busy;
  assign code_run_enable = s_reg.run;

endmodule : csw_clock_switch

// ### include/csw_map.svh
// Purpose: Offsets, fields, reset codes and timing of the clock switch block
// Assumes: 32-bit APB data, one register per aligned word
// Notes: Definitions only
`ifndef CSW_MAP_SVH
`define CSW_MAP_SVH

// Register byte addresses
`define CSW_ADDR_W 12
`define CSW_REQ_OFS 12'h000
`define CSW_STAT_OFS 12'h004

// Field positions inside both registers
`define CSW_SRC_LSB 4
`define CSW_SRC_MSB 6
`define CSW_DIV_LSB 0
`define CSW_DIV_MSB 3

// Source and divider codes
`define CSW_SRC_HF_1M 3'h6
`define CSW_SRC_HF_32M 3'h0
`define CSW_DIV_RST_HF_1M 4'h2
`define CSW_DIV_RST_OTHER 4'h0
`define CSW_DIV_MAX 4'h9

// One bit per source code; a set bit marks that code as reserved
`define CSW_RSVD_MASK 8'h28

// Oscillator settle time and the cycle count derived from it
`define CSW_CLK_MHZ 10
`define CSW_SETTLE_NS 2000
`define CSW_SETTLE_CYC ((`CSW_SETTLE_NS * `CSW_CLK_MHZ + 999) / 1000)

// Synchroniser width and stages before fuses are trusted
`define CSW_SYNC_W 5
`define CSW_SYNC_STAGES 2

`endif

// ### include/csw_pkg.sv
// Purpose: Types shared by the clock switch block
// Assumes: Constants come from csw_map.svh
// Notes: Each module keeps all state in one packed struct
package csw_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    CSW_ST_LOAD,
    CSW_ST_SETTLE,
    CSW_ST_IDLE,
    CSW_ST_SWITCH
  } csw_state_e;

  // Main block state
  typedef struct packed {
    csw_state_e st;
    logic [7:0] cnt;
    logic [2:0] req_src;
    logic [3:0] req_div;
    logic [2:0] cur_src;
    logic [3:0] cur_div;
    logic [2:0] tgt_src;
    logic [3:0] tgt_div;
    logic swen;
    logic hf32;
    logic busy;
    logic run;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } csw_top_s;

  // Synchroniser state
  typedef struct packed {
    logic [4:0] stage1;
    logic [4:0] stage2;
  } csw_sync_s;

  // Postscaler state
  typedef struct packed {
    logic [8:0] cnt;
    logic tick;
  } csw_ps_s;

endpackage : csw_pkg

// ### src/csw_sync.sv
// Purpose: Two-flop synchroniser for fuse and oscillator inputs
// Assumes: Inputs are quasi-static or slow levels
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
`include "csw_map.svh"

module csw_sync (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [`CSW_SYNC_W-1:0] async_in, // Unsynchronised levels
  output logic [`CSW_SYNC_W-1:0] sync_out // Synchronised levels
);

  csw_pkg::csw_sync_s s_reg;
  csw_pkg::csw_sync_s s_next;

  // Shift through two stages
  always_comb begin
    s_next = s_reg;
    s_next.stage1 = async_in;
    s_next.stage2 = s_reg.stage1;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stage2;

endmodule : csw_sync

// ### src/csw_postscaler.sv
// Purpose: Postscaler tick generator for the divider in use
// Assumes: Divider code n selects division by two to the n
// Notes: Codes above the largest ratio are clamped to it
`timescale 1ns/1ps
`include "csw_map.svh"

module csw_postscaler (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [3:0] div_sel, // Divider code in effect
  output logic tick // One pulse per divided period
);

  csw_pkg::csw_ps_s s_reg;
  csw_pkg::csw_ps_s s_next;
  logic [3:0] div_eff;
  logic [8:0] limit;

  // Ratio 1:1 up to 1:512
  always_comb begin
    div_eff = (div_sel > `CSW_DIV_MAX) ? `CSW_DIV_MAX : div_sel; // RULE_14
    limit = 9'((10'h001 << div_eff) - 10'h001); // RULE_14
    s_next = s_reg;
    if (s_reg.cnt >= limit) begin
      s_next.cnt = 9'h000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 9'h001;
      s_next.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule : csw_postscaler

// ### verification/csw_clock_switch_assertions.sv
// Purpose: Port checks for the clock switch block
// Assumes: One pclk domain, presetn async active low
// Notes: Attached to the top module by bind
`timescale 1ns/1ps
module csw_clock_switch_chk (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [2:0] clk_src_sel, // Source to mux
  input wire logic [3:0] clk_div_sel, // Divider to postscaler
  input wire logic switch_busy, // Switch in progress
  input wire logic code_run_enable, // User code may run
  input wire logic div_tick // Postscaler pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer, width and error data
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready is not a one-cycle answer");
  a_bit7_zero: assert property (
    pready && !pwrite |-> prdata[31:7] == '0)
    else $error("read data above bit 6 not zero");
  a_err_nodata: assert property (pslverr |-> pready && prdata == '0)
    else $error("error answer carries data");
  // Switch start, minimum settle and run flag
  a_switch_busy: assert property (
    $changed(clk_src_sel) && code_run_enable |-> switch_busy)
    else $error("source moved without a switch");
  a_settle_min: assert property (
    $rose(switch_busy) |-> switch_busy[*8])
    else $error("switch ended before settle time");
  a_run_sticky: assert property (
    code_run_enable |=> code_run_enable)
    else $error("run enable dropped");
  // Postscaler ticks follow the divider code
  a_tick_gap: assert property (
    div_tick && clk_div_sel != 4'h0 && $stable(clk_div_sel)
    |=> !div_tick || $changed(clk_div_sel))
    else $error("ticks too close for divider");
  a_tick_code0: assert property (
    code_run_enable && clk_div_sel == 4'h0 && $past(clk_div_sel) == 4'h0
    |-> div_tick)
    else $error("no tick at divide by one");
endmodule : csw_clock_switch_chk

bind csw_clock_switch csw_clock_switch_chk i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clk_src_sel(clk_src_sel), .clk_div_sel(clk_div_sel),
  .switch_busy(switch_busy), .code_run_enable(code_run_enable),
  .div_tick(div_tick));

// ### verification/testbench.sv
// Purpose: Self-checking bench for the clock switch block
// Assumes: APB master on pclk, 100 ns period
// Notes: Model keeps the request value as an integer
`timescale 1ns/1ps
`include "csw_map.svh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = '0, clk_div_sel;
  logic [2:0] fuse = '0, clk_src_sel;
  logic pready, pslverr, osc_ready = 0, sw_en = 0, err;
  logic hf_freq_32m, switch_busy, code_run_enable, div_tick;
  integer n_fail = 0, n_tests = 0, seed = 35, req, k, i, j, d, s;
  always #50 pclk = ~pclk;
  // Oscillator ready wanders so switches wait a random time
  always @(posedge pclk) osc_ready <= $random(seed);
  csw_clock_switch i_csw_clock_switch (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_source_config(fuse),
    .switch_enable_config(sw_en), .osc_ready(osc_ready),
    .clk_src_sel(clk_src_sel), .clk_div_sel(clk_div_sel),
    .hf_freq_32m(hf_freq_32m), .switch_busy(switch_busy),
    .code_run_enable(code_run_enable), .div_tick(div_tick));
  // Verdict and end of run
  task print_verdict;
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Compare one value and count it
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // A wait that ran out ends the run
  task hang(input integer n);
    chk("wait_done", 1, n < 3000);
    if (n >= 3000) print_verdict;
  endtask : hang
  // One APB transfer, held until pready is sampled high
  task apb(input [11:0] a, input w, input [31:0] dw, input [3:0] st);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= dw;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1 && k < 50);
    if (k >= 50) hang(3000);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task rdchk(input string nm, input [11:0] a, input [31:0] e);
    apb(a, 0, 0, 4'h0);
    chk(nm, e, rd);
    chk("err_ok", 0, err);
  endtask : rdchk
  // Gap between two postscaler ticks for the divider in use
  task tick_chk(input integer dv);
    for (k = 0; k < 3000 && div_tick !== 1; k++) @(posedge pclk);
    hang(k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (div_tick !== 1 && k < 3000);
    hang(k);
    chk("tick_gap", 1 << ((dv > `CSW_DIV_MAX) ? `CSW_DIV_MAX : dv), k);
  endtask : tick_chk
  // Reset with the given fuse levels, then wait for run enable
  task do_reset(input [2:0] f, input bit en);
    presetn <= 0;
    fuse <= f;
    sw_en <= en;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    for (k = 0; k < 3000 && code_run_enable !== 1; k++) @(posedge pclk);
    hang(k);
  endtask : do_reset
  // Every usable fuse code; switching disabled for code 4
  initial begin
    @(posedge pclk);
    for (i = 0; i < 8; i++) begin
      if ((`CSW_RSVD_MASK >> i) & 1) continue;
      do_reset(i[2:0], i != 4);
      req = i * 16 + (i == 6 ? 2 : 0);
      chk("hf32", i == 0, hf_freq_32m);
      rdchk("req_rst", `CSW_REQ_OFS, req);
      rdchk("stat_rst", `CSW_STAT_OFS, req);
      for (j = 0; j < 6; j++) begin
        d = $random(seed) & 255;
        s = $random(seed);
        if (j < 2) s = 1;
        if (j < 2) d = j * 32 + 48 + (d & 15);
        if (sw_en && s[0] && !((`CSW_RSVD_MASK >> (d / 16 % 8)) & 1))
          req = d & 127;
        apb(`CSW_REQ_OFS, 1, d, s[3:0]);
        rdchk("req", `CSW_REQ_OFS, req);
        repeat (2) @(posedge pclk);
        for (k = 0; k < 3000 && switch_busy !== 0; k++) @(posedge pclk);
        hang(k);
        rdchk("stat", `CSW_STAT_OFS, req);
        chk("src", req / 16, clk_src_sel);
        chk("div", req % 16, clk_div_sel);
        tick_chk(req % 16);
      end
      // Status ignores writes; unmapped word answers with an error
      apb(`CSW_STAT_OFS, 1, 32'hFFFF_FFFF, 4'hF);
      rdchk("stat_ro", `CSW_STAT_OFS, req);
      apb(12'h008, 0, 0, 4'h0);
      chk("err", 1, err);
      chk("rd0", 0, rd);
    end
    print_verdict;
  end
endmodule : testbench
